// ---- hdl/rcfg_pkg.sv ----
// Constants for the reader configuration register bank
package rcfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CRC_HIGH    = 8'h24;
  localparam logic [7:0] IDX_FIXED_A     = 8'h25;
  localparam logic [7:0] IDX_MON_SRC     = 8'h26;
  localparam logic [7:0] IDX_FIXED_B     = 8'h27;
  localparam logic [7:0] IDX_FIFO_LEVEL  = 8'h29;
  localparam logic [7:0] IDX_TIMER_CLK   = 8'h2A;
  localparam logic [7:0] IDX_TIMER_RLD   = 8'h2C;
  localparam logic [7:0] IDX_CONTROL     = 8'h30;
  localparam logic [7:0] IDX_STATUS      = 8'h31;
  // Reset values
  localparam logic [7:0] RST_CRC_HIGH    = 8'h63;
  localparam logic [7:0] RST_FIXED_A     = 8'h00;
  localparam logic [7:0] RST_FIXED_B     = 8'h00;
  localparam logic [7:0] RST_MON_SRC     = 8'h00;
  localparam logic [7:0] RST_FIFO_LEVEL  = 8'h08;
  localparam logic [7:0] RST_TIMER_CLK   = 8'h07;
  localparam logic [7:0] RST_TIMER_RLD   = 8'h0A;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  // Field positions
  localparam int MON_SEL_LSB   = 0;
  localparam int LEVEL_LSB     = 0;
  localparam int PRESC_LSB     = 0;
  localparam int AUTO_BIT      = 5;
  localparam int CTL_CRC_EN    = 0;
  localparam int CTL_SHORT_CRC = 1;
  localparam int ST_FULL       = 0;
  localparam int ST_EMPTY      = 1;
  localparam int ST_EXPIRED    = 2;
  localparam int ST_RUNNING    = 3;
  localparam int ST_COUNT_LSB  = 8;
  // Timer clock
  localparam int  READER_CLK_KHZ = 13560;
  localparam int  SYS_CLK_KHZ    = 40000;
  localparam logic [4:0] PRESC_MAX = 5'h15;
  // Monitor source codes
  typedef enum logic [2:0] {
    RCFG_MON_LOW     = 3'h0,
    RCFG_MON_HIGH    = 3'h1,
    RCFG_MON_MILLER  = 3'h2,
    RCFG_MON_SERIAL  = 3'h3,
    RCFG_MON_CARRIER = 3'h4,
    RCFG_MON_SUBCARR = 3'h5
  } rcfg_mon_t;
  // Timer states
  typedef enum logic [0:0] {
    RCFG_T_IDLE = 1'h0,
    RCFG_T_RUN  = 1'h1
  } rcfg_tstate_t;
endpackage : rcfg_pkg

// ---- hdl/rcfg_timer_prescaler.sv ----
// Timer tick generator: reader clock rate divided by a power of two
`timescale 1ns/100ps
module rcfg_timer_prescaler
  import rcfg_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Control
  input  wire logic [4:0] i_exponent,
  // Tick
  output logic            o_tick
);
  localparam logic [15:0] ACC_STEP = 16'(READER_CLK_KHZ);
  localparam logic [15:0] ACC_WRAP = 16'(SYS_CLK_KHZ);

  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic [20:0] div_reg;
  logic [20:0] div_next;
  logic        tick_reg;
  logic        tick_next;
  logic        base;
  logic [4:0]  expo;
  logic [20:0] mask;

  // Fractional accumulator recreates reader clock edges on the system clock
  always_comb
  begin
    base      = 1'b0;
    acc_next  = acc_reg + ACC_STEP;
    if (acc_next >= ACC_WRAP)
    begin
      acc_next = acc_next - ACC_WRAP;
      base     = 1'b1;
    end
    // Out of range exponents are clamped rather than aliased
    expo      = (i_exponent > PRESC_MAX) ? PRESC_MAX : i_exponent;
    mask      = 21'((22'h1 << expo) - 22'h1);
    div_next  = div_reg;
    tick_next = 1'b0;
    if (base)
    begin
      if ((div_reg & mask) == mask)
      begin
        div_next  = '0;
        tick_next = 1'b1;
      end
      else
      begin
        div_next = div_reg + 21'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      acc_reg  <= '0;
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg  <= acc_next;
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;
endmodule : rcfg_timer_prescaler

// ---- hdl/rcfg_regs.sv ----
// Reader configuration registers: CRC preset, monitor mux, FIFO levels, timer
//
// Functional notes
// - With CRC enabled, the high start byte is loaded at each tx, rx or CRC command start.
// - With short CRC selected, the high byte is ignored and only the low byte is used.
// - Monitor code 000 drives the pin low and 001 drives it high.
// - Code 010 gives the Miller envelope, 011 the serial data before Miller coding.
// - Codes 100 and 101 give the demodulator outputs, only for type A at base rate.
// - Nearly-full is set while free FIFO space is at or below the threshold.
// - Nearly-empty is set while FIFO fill is at or below the threshold.
// - With auto reload set, the timer reloads at the end of count and keeps going.
// - With auto reload clear, the timer stops at zero and sets the expired flag.
// - The timer ticks at the reader clock divided by two to the exponent.
// - A start loads the reload value; zero reload prevents the start.
// - Short CRC select means an 8-bit CRC, clear means 16-bit.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module rcfg_regs
  import rcfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // CRC engine side
  input  wire logic        i_tx_start,
  input  wire logic        i_rx_start,
  input  wire logic        i_crc_compute_command,
  input  wire logic [7:0]  i_crc_start_low_byte,
  output logic             o_crc_load,
  output logic [15:0]      o_crc_start_value,
  output logic             o_short_crc_select,
  // Monitor sources and pin
  input  wire logic        i_miller_envelope,
  input  wire logic        i_tx_serial_data,
  input  wire logic        i_carrier_demod,
  input  wire logic        i_subcarrier_demod,
  input  wire logic        i_type_a_base_rate,
  output logic             o_monitor_output_pin,
  // FIFO fill level and flags
  input  wire logic [6:0]  i_fifo_fill,
  output logic             o_fifo_nearly_full_flag,
  output logic             o_fifo_nearly_empty_flag,
  // Timer events and state
  input  wire logic        i_timer_start,
  input  wire logic        i_timer_stop,
  output logic             o_timer_expired_flag,
  output logic             o_timer_running
);

  // Bus state
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        req;
  logic        wr_now;
  logic [7:0]  idx;
  logic [7:0]  wbyte;

  // Register state
  logic [7:0] crc_high_reg;
  logic [7:0] crc_high_next;
  logic [7:0] fixed_a_reg;
  logic [7:0] fixed_a_next;
  logic [7:0] fixed_b_reg;
  logic [7:0] fixed_b_next;
  logic [7:0] mon_src_reg;
  logic [7:0] mon_src_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic [7:0] tclk_reg;
  logic [7:0] tclk_next;
  logic [7:0] reload_reg;
  logic [7:0] reload_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic       exp_clear;

  // Datapath outputs
  logic        crc_load_reg;
  logic        crc_load_next;
  logic [15:0] crc_val_reg;
  logic [15:0] crc_val_next;
  logic        mon_reg;
  logic        mon_next;
  logic        full_reg;
  logic        full_next;
  logic        empty_reg;
  logic        empty_next;
  logic [6:0]  free_space;
  logic [6:0]  threshold;

  // Timer state
  rcfg_tstate_t tstate_reg;
  rcfg_tstate_t tstate_next;
  logic [7:0]   tcount_reg;
  logic [7:0]   tcount_next;
  logic         expired_reg;
  logic         expired_next;
  logic         tick;

  // Bus: one wait cycle, then the request is answered and waitrequest drops
  always_comb
  begin
    req        = i_avs_read | i_avs_write;
    idx        = i_avs_address[9:2];
    wr_now     = i_avs_write & ~wait_reg & i_avs_byteenable[0];
    wbyte      = i_avs_writedata[7:0];
    wait_next  = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (req & wait_reg & i_avs_read)
    begin
      rdata_next = '0;
      case (idx)
        IDX_CRC_HIGH:   rdata_next[7:0] = crc_high_reg;
        IDX_FIXED_A:    rdata_next[7:0] = fixed_a_reg;
        IDX_MON_SRC:    rdata_next[7:0] = mon_src_reg;
        IDX_FIFO_LEVEL: rdata_next[7:0] = level_reg;
        IDX_TIMER_CLK:  rdata_next[7:0] = tclk_reg;
        IDX_TIMER_RLD:  rdata_next[7:0] = reload_reg;
        IDX_CONTROL:    rdata_next[7:0] = ctrl_reg;
        IDX_STATUS:
        begin
          rdata_next[ST_FULL]    = full_reg;
          rdata_next[ST_EMPTY]   = empty_reg;
          rdata_next[ST_EXPIRED] = expired_reg;
          rdata_next[ST_RUNNING] = (tstate_reg == RCFG_T_RUN);
          rdata_next[ST_COUNT_LSB +: 8] = tcount_reg;
        end
        // Write-only fixed register and unmapped words read as zero
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end
    else
    begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes take effect on the edge where waitrequest is low
  always_comb
  begin
    crc_high_next = crc_high_reg;
    fixed_a_next  = fixed_a_reg;
    fixed_b_next  = fixed_b_reg;
    mon_src_next  = mon_src_reg;
    level_next    = level_reg;
    tclk_next     = tclk_reg;
    reload_next   = reload_reg;
    ctrl_next     = ctrl_reg;
    exp_clear     = 1'b0;
    if (wr_now)
    begin
      case (idx)
        IDX_CRC_HIGH:   crc_high_next = wbyte;
        IDX_FIXED_A:    fixed_a_next  = wbyte;
        IDX_FIXED_B:    fixed_b_next  = wbyte;
        IDX_MON_SRC:    mon_src_next  = wbyte;
        IDX_FIFO_LEVEL: level_next    = wbyte;
        IDX_TIMER_CLK:  tclk_next     = wbyte;
        IDX_TIMER_RLD:  reload_next   = wbyte;
        IDX_CONTROL:    ctrl_next     = wbyte;
        IDX_STATUS:     exp_clear     = wbyte[ST_EXPIRED];
        default:        exp_clear     = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      crc_high_reg <= RST_CRC_HIGH;
      fixed_a_reg  <= RST_FIXED_A;
      fixed_b_reg  <= RST_FIXED_B;
      mon_src_reg  <= RST_MON_SRC;
      level_reg    <= RST_FIFO_LEVEL;
      tclk_reg     <= RST_TIMER_CLK;
      reload_reg   <= RST_TIMER_RLD;
      ctrl_reg     <= RST_CONTROL;
    end
    else
    begin
      crc_high_reg <= crc_high_next;
      fixed_a_reg  <= fixed_a_next;
      fixed_b_reg  <= fixed_b_next;
      mon_src_reg  <= mon_src_next;
      level_reg    <= level_next;
      tclk_reg     <= tclk_next;
      reload_reg   <= reload_next;
      ctrl_reg     <= ctrl_next;
    end
  end

  // CRC preset, monitor mux and FIFO flags
  always_comb
  begin
    crc_load_next = ctrl_reg[CTL_CRC_EN] &
                    (i_tx_start | i_rx_start | i_crc_compute_command);
    crc_val_next  = crc_val_reg;
    if (crc_load_next)
    begin
      if (ctrl_reg[CTL_SHORT_CRC])
      begin
        crc_val_next = {8'h00, i_crc_start_low_byte};
      end
      else
      begin
        crc_val_next = {crc_high_reg, i_crc_start_low_byte};
      end
    end
    case (mon_src_reg[MON_SEL_LSB +: 3])
      RCFG_MON_LOW:     mon_next = 1'b0;
      RCFG_MON_HIGH:    mon_next = 1'b1;
      RCFG_MON_MILLER:  mon_next = i_miller_envelope;
      RCFG_MON_SERIAL:  mon_next = i_tx_serial_data;
      // Demodulator taps mean nothing outside type A base rate, so hold low
      RCFG_MON_CARRIER: mon_next = i_carrier_demod & i_type_a_base_rate;
      RCFG_MON_SUBCARR: mon_next = i_subcarrier_demod & i_type_a_base_rate;
      default:          mon_next = 1'b0;
    endcase
    threshold  = {1'b0, level_reg[LEVEL_LSB +: 6]};
    free_space = 7'(FIFO_DEPTH) - i_fifo_fill;
    full_next  = (free_space <= threshold);
    empty_next = (i_fifo_fill <= threshold);
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      crc_load_reg <= 1'b0;
      crc_val_reg  <= '0;
      mon_reg      <= 1'b0;
      full_reg     <= 1'b0;
      empty_reg    <= 1'b1;
    end
    else
    begin
      crc_load_reg <= crc_load_next;
      crc_val_reg  <= crc_val_next;
      mon_reg      <= mon_next;
      full_reg     <= full_next;
      empty_reg    <= empty_next;
    end
  end

  rcfg_timer_prescaler i_rcfg_timer_prescaler
  (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_exponent (tclk_reg[PRESC_LSB +: 5]),
    .o_tick     (tick)
  );

  // Timer: a start with nonzero reload also restarts a running timer; stop wins over start
  always_comb
  begin
    tstate_next  = tstate_reg;
    tcount_next  = tcount_reg;
    expired_next = expired_reg & ~exp_clear;
    if (i_timer_stop)
    begin
      tstate_next = RCFG_T_IDLE;
    end
    else if (i_timer_start)
    begin
      if (reload_reg != 8'h00)
      begin
        tstate_next = RCFG_T_RUN;
        tcount_next = reload_reg;
      end
    end
    else
    begin
      case (tstate_reg)
        RCFG_T_RUN:
        begin
          if (tick)
          begin
            if (tcount_reg > 8'h01)
            begin
              tcount_next = tcount_reg - 8'h01;
            end
            else if (tclk_reg[AUTO_BIT])
            begin
              tcount_next = reload_reg;
            end
            else
            begin
              tcount_next  = 8'h00;
              tstate_next  = RCFG_T_IDLE;
              expired_next = 1'b1;
            end
          end
        end
        default:
        begin
          tstate_next = RCFG_T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tstate_reg  <= RCFG_T_IDLE;
      tcount_reg  <= '0;
      expired_reg <= 1'b0;
    end
    else
    begin
      tstate_reg  <= tstate_next;
      tcount_reg  <= tcount_next;
      expired_reg <= expired_next;
    end
  end

  // Outputs
  assign o_avs_readdata           = rdata_reg;
  assign o_avs_waitrequest        = wait_reg;
  assign o_crc_load               = crc_load_reg;
  assign o_crc_start_value        = crc_val_reg;
  assign o_short_crc_select       = ctrl_reg[CTL_SHORT_CRC];
  assign o_monitor_output_pin     = mon_reg;
  assign o_fifo_nearly_full_flag  = full_reg;
  assign o_fifo_nearly_empty_flag = empty_reg;
  assign o_timer_expired_flag     = expired_reg;
  assign o_timer_running          = (tstate_reg == RCFG_T_RUN);
endmodule : rcfg_regs

// ---- sim/rcfg_regs_asserts.sv ----
// Checker for the reader configuration register bank
`timescale 1ns/100ps
module rcfg_regs_asserts
  import rcfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
)
(
  // Clock, reset and bus
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [9:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  // CRC
  input wire logic        i_tx_start,
  input wire logic        i_rx_start,
  input wire logic        i_crc_compute_command,
  input wire logic [7:0]  i_crc_start_low_byte,
  input wire logic        o_crc_load,
  input wire logic [15:0] o_crc_start_value,
  input wire logic        o_short_crc_select,
  // Monitor
  input wire logic        i_miller_envelope,
  input wire logic        i_tx_serial_data,
  input wire logic        i_carrier_demod,
  input wire logic        i_subcarrier_demod,
  input wire logic        i_type_a_base_rate,
  input wire logic        o_monitor_output_pin,
  // FIFO and timer
  input wire logic [6:0]  i_fifo_fill,
  input wire logic        o_fifo_nearly_full_flag,
  input wire logic        o_fifo_nearly_empty_flag,
  input wire logic        i_timer_stop,
  input wire logic        o_timer_running,
  input wire logic        o_timer_expired_flag
);
  // Field shadows take only the field bits of bus writes, as the bank decodes them, so reserved bits are ignored
  logic       up, en_sh, auto_sh, hit, full_x, empty_x;
  logic [2:0] mon_sh;
  logic [5:0] lvl_sh;
  logic [7:0] idx;
  assign idx = i_avs_address[9:2];
  assign hit = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign full_x = (7'(FIFO_DEPTH) - i_fifo_fill) <= {1'b0, lvl_sh};
  assign empty_x = i_fifo_fill <= {1'b0, lvl_sh};
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      up      <= 1'b0;
      en_sh   <= 1'b0;
      auto_sh <= 1'b0;
      mon_sh  <= 3'h0;
      lvl_sh  <= RST_FIFO_LEVEL[5:0];
    end
    else
    begin
      up <= 1'b1;
      if (hit && idx == IDX_CONTROL) en_sh <= i_avs_writedata[0];
      if (hit && idx == IDX_TIMER_CLK) auto_sh <= i_avs_writedata[5];
      if (hit && idx == IDX_MON_SRC) mon_sh <= i_avs_writedata[2:0];
      if (hit && idx == IDX_FIFO_LEVEL) lvl_sh <= i_avs_writedata[5:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_crc_load_start: assert property (
    $past(en_sh && (i_tx_start || i_rx_start || i_crc_compute_command)) |-> o_crc_load)
    else $error("crc load missing");
  a_crc_load_cause: assert property (
    o_crc_load |-> $past(en_sh && (i_tx_start || i_rx_start || i_crc_compute_command)))
    else $error("crc load without start");
  a_short_crc_val: assert property (
    o_crc_load && $past(o_short_crc_select) |->
    o_crc_start_value == {8'h00, $past(i_crc_start_low_byte)})
    else $error("short crc start value");
  a_mon_const: assert property (
    $past(mon_sh) < 3'h2 |-> o_monitor_output_pin == $past(mon_sh[0]))
    else $error("monitor constant");
  a_mon_coder: assert property (
    $past(mon_sh[2:1]) == 2'b01 |->
    o_monitor_output_pin == $past(mon_sh[0] ? i_tx_serial_data : i_miller_envelope))
    else $error("monitor coder source");
  a_mon_demod: assert property (
    $past(mon_sh[2:1]) == 2'b10 |-> o_monitor_output_pin ==
    $past((mon_sh[0] ? i_subcarrier_demod : i_carrier_demod) && i_type_a_base_rate))
    else $error("monitor demodulator source");
  a_mon_reserved: assert property (
    $past(mon_sh[2:1]) == 2'b11 |-> !o_monitor_output_pin)
    else $error("monitor reserved code");
  a_fifo_full: assert property (
    up |-> o_fifo_nearly_full_flag == $past(full_x))
    else $error("nearly full flag");
  a_fifo_empty: assert property (
    up |-> o_fifo_nearly_empty_flag == $past(empty_x))
    else $error("nearly empty flag");
  a_auto_keep: assert property (
    auto_sh && $past(o_timer_running) && !$past(i_timer_stop) |-> o_timer_running)
    else $error("auto reload timer stopped");
  a_stop_expire: assert property (
    up && $fell(o_timer_running) && !$past(i_timer_stop) |-> o_timer_expired_flag)
    else $error("timer ended without expiry");
  c_short_load: cover property (o_crc_load && o_short_crc_select);
  c_expired: cover property ($fell(o_timer_running) && o_timer_expired_flag);
  c_both_flags: cover property (o_fifo_nearly_full_flag && o_fifo_nearly_empty_flag);
endmodule : rcfg_regs_asserts

// ---- sim/rcfg_regs_tb.sv ----
// Self-checking testbench for the reader configuration register bank
`timescale 1ns/100ps
module rcfg_regs_tb;
  import rcfg_pkg::*;
  logic        i_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [9:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [3:0]  i_avs_byteenable;
  logic        i_tx_start, i_rx_start, i_crc_compute_command, o_crc_load;
  logic [7:0]  i_crc_start_low_byte, hi, d;
  logic [15:0] o_crc_start_value;
  logic        o_short_crc_select, o_monitor_output_pin, i_timer_start, i_timer_stop;
  logic [4:0]  src;
  logic [6:0]  i_fifo_fill;
  logic        o_fifo_nearly_full_flag, o_fifo_nearly_empty_flag;
  logic        o_timer_expired_flag, o_timer_running;
  int          num_errors, samples_checked, seed, cycles, n;
  logic [7:0]  ridx [9] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2A, 8'h2C, 8'h30, 8'h3F};
  logic [7:0]  rval [9] = '{8'h63, 8'h00, 8'h00, 8'h00, 8'h08, 8'h07, 8'h0A, 8'h00, 8'h00};
  logic [7:0]  wtab [4] = '{8'h24, 8'h26, 8'h29, 8'h2C};
  logic [7:0]  wmsk [4] = '{8'hFF, 8'h07, 8'h3F, 8'hFF};

  rcfg_regs #(.FIFO_DEPTH(64)) i_rcfg_regs (
    .i_clk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_tx_start, .i_rx_start,
    .i_crc_compute_command, .i_crc_start_low_byte, .o_crc_load, .o_crc_start_value,
    .o_short_crc_select, .i_miller_envelope(src[4]), .i_tx_serial_data(src[3]),
    .i_carrier_demod(src[2]), .i_subcarrier_demod(src[1]), .i_type_a_base_rate(src[0]),
    .o_monitor_output_pin, .i_fifo_fill, .o_fifo_nearly_full_flag,
    .o_fifo_nearly_empty_flag, .i_timer_start, .i_timer_stop, .o_timer_expired_flag,
    .o_timer_running);

  always #12.5 i_clk = ~i_clk;

  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request holds until waitrequest is seen low at a rising edge; one idle edge follows
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    i_avs_address <= {a, 2'b00};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= {24'h0, wd};
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (o_avs_waitrequest !== 1'b0 && k < 40);
    q = o_avs_readdata;
    if (k >= 40) num_errors++;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus

  task automatic tstart;
    i_timer_start <= 1'b1;
    @(posedge i_clk);
    i_timer_start <= 1'b0;
    @(negedge i_clk);
  endtask : tstart

  function automatic logic mon_exp(input logic [2:0] c, input logic [4:0] s);
    logic [7:0] v;
    v = {2'b00, s[1] & s[0], s[2] & s[0], s[3], s[4], 2'b10};
    return v[c];
  endfunction : mon_exp

  function automatic int t_cyc(input int r, input int e);
    return r * (SYS_CLK_KHZ << e) / READER_CLK_KHZ;
  endfunction : t_cyc

  initial
  begin
    {i_clk, i_reset_n, i_avs_read, i_avs_write, i_tx_start, i_rx_start} = '0;
    {i_crc_compute_command, i_timer_start, i_timer_stop, src, i_fifo_fill} = '0;
    {i_avs_address, i_avs_writedata, i_crc_start_low_byte} = '0;
    i_avs_byteenable = 4'hF;
    seed = 47643;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 9; i++)
    begin
      bus(0, ridx[i], 8'h00);
      check("reset value", q, {24'h0, rval[i]});
    end
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($random(seed)) & wmsk[i % 4];
      bus(1, wtab[i % 4], d);
      bus(0, wtab[i % 4], 8'h00);
      check("readback", q, {24'h0, d});
    end
    for (int i = 0; i < 12; i++)
    begin
      hi = 8'($random(seed));
      d = 8'(i / 3);
      bus(1, 8'h24, hi);
      bus(1, IDX_CONTROL, d);
      i_crc_start_low_byte <= 8'($random(seed));
      i_tx_start <= (i % 3 == 0);
      i_rx_start <= (i % 3 == 1);
      i_crc_compute_command <= (i % 3 == 2);
      @(posedge i_clk);
      {i_tx_start, i_rx_start, i_crc_compute_command} <= 3'h0;
      @(negedge i_clk);
      check("crc load", o_crc_load, d[0]);
      check("crc value", o_crc_start_value & {16{d[0]}},
            (d[1] ? {8'h00, i_crc_start_low_byte} : {hi, i_crc_start_low_byte}) & {16{d[0]}});
      check("short select", o_short_crc_select, d[1]);
      @(posedge i_clk);
    end
    // Disabled byte lane and unmapped write must leave the bank untouched
    i_avs_byteenable <= 4'h0;
    bus(1, 8'h24, ~hi);
    i_avs_byteenable <= 4'hF;
    bus(1, 8'h3F, 8'hA5);
    bus(0, 8'h24, 8'h00);
    check("lane off", q, {24'h0, hi});
    bus(0, 8'h3F, 8'h00);
    check("unmapped", q, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 8'h26, 8'(c));
      for (int k = 0; k < 6; k++)
      begin
        src <= 5'($random(seed));
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("monitor pin", o_monitor_output_pin, mon_exp(3'(c), src));
        @(posedge i_clk);
      end
    end
    for (int k = 0; k < 40; k++)
    begin
      d = (k < 4) ? 8'(k * 21) : 8'($random(seed)) & 8'h3F;
      bus(1, 8'h29, d);
      i_fifo_fill <= (k < 8) ? 7'(k[0] * 64) : 7'($unsigned($random(seed)) % 65);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      check("nearly full", o_fifo_nearly_full_flag, (64 - i_fifo_fill) <= d[5:0]);
      check("nearly empty", o_fifo_nearly_empty_flag, i_fifo_fill <= d[5:0]);
      @(posedge i_clk);
    end
    bus(1, 8'h2C, 8'h14);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, 8'h2A, 8'(k));
      tstart();
      n = 0;
      do
      begin
        @(negedge i_clk);
        n++;
      end
      while (o_timer_expired_flag !== 1'b1 && n < 2000);
      check("tick late", n <= t_cyc(20, k) + (4 << k) + 2, 1);
      check("tick early", n + (4 << k) + 2 >= t_cyc(20, k), 1);
      check("stopped", o_timer_running, 1'b0);
      @(posedge i_clk);
      bus(1, IDX_STATUS, 8'h04);
      bus(0, IDX_STATUS, 8'h00);
      check("expired cleared", q[3:2], 2'b00);
    end
    bus(1, 8'h2A, 8'h20);
    tstart();
    repeat (200) @(negedge i_clk);
    check("auto running", {o_timer_running, o_timer_expired_flag}, 2'b10);
    @(posedge i_clk);
    i_timer_stop <= 1'b1;
    @(posedge i_clk);
    i_timer_stop <= 1'b0;
    bus(1, 8'h2C, 8'h00);
    tstart();
    check("zero reload", o_timer_running, 1'b0);
    @(posedge i_clk);
    end_sim();
  end
endmodule : rcfg_regs_tb

bind rcfg_regs rcfg_regs_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_rcfg_regs_asserts (.*);
